// ===== hdl/mce_pkg.sv
// Overview of operation
// - power-control and uncore internal errors go only to the internal-error bank.
// - memory-controller errors go to banks 9 to 16, one misc register per bank.
// - bit 1 of the extended log control register enables the extended logging.
// - misc 13:9 holds buffer id on write parity, else second device on read.
// - with extended logging on, first device bit mask goes to misc 29:14.
// - with extended logging on, second device bit mask goes to misc 45:30.
// - with extended logging on, first device failing rank goes to misc 50:46.
// - with extended logging on, second device failing rank goes to misc 55:51.
// - misc bit 62 is set once first device correctable read data is captured.
// - misc bit 63 marks second device data; trust it only with bit 62 set.
// - internal code is 0402h/0403h power control, 0406h trusted, 0407h utility.
// - core three-strike copies cache bank status in and disables core banks.
// - status 19:16 reads 0000b for no error, 00xxb for power-control errors.
package mce_pkg;

	// ------------------------------------------------------------
	// bank numbering
	// ------------------------------------------------------------
	localparam int NUM_BANKS = 8;
	localparam logic [4:0] FIRST_BANK = 5'h09;

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [11:0] OFF_EXT_CTRL = 12'h000;
	localparam logic [11:0] OFF_INT_LO = 12'h004;
	localparam logic [11:0] OFF_INT_HI = 12'h008;
	localparam logic [11:0] OFF_CORE = 12'h00C;
	localparam logic [11:0] OFF_DROP = 12'h010;
	localparam logic [11:0] OFF_MISC_BASE = 12'h100;
	localparam logic [11:0] MISC_STRIDE = 12'h008;

	// ------------------------------------------------------------
	// field positions and reset values
	// ------------------------------------------------------------
	localparam int EXT_EN_BIT = 1;
	localparam logic EXT_EN_RESET = 1'b0;
	localparam int WBUF_LSB = 9;
	localparam int MASK1_LSB = 14;
	localparam int MASK2_LSB = 30;
	localparam int RANK1_LSB = 46;
	localparam int RANK2_LSB = 51;
	localparam int VALID1_BIT = 62;
	localparam int VALID2_BIT = 63;
	localparam logic [15:0] ONES5 = 16'h001F;
	localparam logic [15:0] ONES16 = 16'hFFFF;
	localparam logic [63:0] MISC_SW_MASK = 64'h00FF_FFFF_FFFF_FE00;
	localparam int CODE_LSB = 0;
	localparam int SUB_LSB = 16;
	localparam int DETAIL_LSB = 24;
	localparam int INT_VALID_BIT = 63;
	localparam logic [63:0] INT_STATUS_RESET = 64'h0000_0000_0000_0000;

	// ------------------------------------------------------------
	// internal error codes
	// ------------------------------------------------------------
	localparam logic [15:0] CODE_PWR_A = 16'h0402;
	localparam logic [15:0] CODE_PWR_B = 16'h0403;
	localparam logic [15:0] CODE_TRUSTED = 16'h0406;
	localparam logic [15:0] CODE_UTILITY = 16'h0407;
	localparam logic [3:0] SUB_NO_ERROR = 4'h0;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		MCE_KIND_WR_DATA_PAR = 2'h0,
		MCE_KIND_WR_BE_PAR = 2'h1,
		MCE_KIND_CORR_READ = 2'h2,
		MCE_KIND_OTHER = 2'h3
	} mce_mc_kind_t;

	typedef enum logic [1:0] {
		MCE_SRC_PWR_A = 2'h0,
		MCE_SRC_PWR_B = 2'h1,
		MCE_SRC_TRUSTED = 2'h2,
		MCE_SRC_UTILITY = 2'h3
	} mce_int_src_t;

	typedef struct packed {
		logic valid;
		logic [4:0] bank;
		mce_mc_kind_t kind;
		logic [4:0] wbuf_id;
		logic [4:0] device;
		logic [15:0] bit_mask;
		logic [4:0] rank;
	} mce_mc_evt_t;

	typedef struct packed {
		logic valid;
		mce_int_src_t src;
		logic [1:0] pwr_sub;
		logic [7:0] detail;
	} mce_int_evt_t;

	typedef struct packed {
		logic valid;
		logic [63:0] cache_status;
	} mce_strike_evt_t;

	typedef struct packed {
		logic valid;
		logic hi;
		logic [31:0] data;
	} mce_sw_wr_t;

	typedef enum logic [3:0] {
		MCE_ST_IDLE = 4'b0001,
		MCE_ST_RD = 4'b0010,
		MCE_ST_RD2 = 4'b0100,
		MCE_ST_WR = 4'b1000
	} mce_state_t;

endpackage

// ===== hdl/mce_misc_mem.sv
`timescale 1ns/1ps
module mce_misc_mem #(
	parameter int DEPTH = 8,
	parameter int WIDTH = 64,
	parameter int AW = 3
) (
	input wire logic clk,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [WIDTH-1:0] wmask,
	input wire logic [WIDTH-1:0] wdata,
	input wire logic re,
	input wire logic [AW-1:0] raddr,
	output logic [WIDTH-1:0] rdata
);

	if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_chk
		$error("mce_misc_mem: DEPTH does not fit AW");
	end

	logic [WIDTH-1:0] mem [DEPTH];

	// bit-masked write keeps first-device fields when the second is logged
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= (mem[waddr] & ~wmask) | (wdata & wmask);
		end
		if (re) begin
			rdata <= mem[raddr];
		end
	end

endmodule

// ===== hdl/mce_int_log.sv
`timescale 1ns/1ps
module mce_int_log (
	input wire logic clk,
	input wire logic rstn,
	input mce_pkg::mce_int_evt_t int_evt,
	input mce_pkg::mce_strike_evt_t strike_evt,
	input mce_pkg::mce_sw_wr_t sw_wr,
	output logic [63:0] status,
	output logic core_off
);

	logic [63:0] status_reg;
	logic [63:0] status_next;
	logic core_off_reg;
	logic core_off_next;
	logic [15:0] code;
	logic [3:0] sub;

	always_comb begin
		status_next = status_reg;
		core_off_next = core_off_reg;
		code = mce_pkg::CODE_UTILITY;
		sub = mce_pkg::SUB_NO_ERROR;
		case (int_evt.src)
			mce_pkg::MCE_SRC_PWR_A: begin
				code = mce_pkg::CODE_PWR_A;
				sub = {2'b00, int_evt.pwr_sub};
			end
			mce_pkg::MCE_SRC_PWR_B: begin
				code = mce_pkg::CODE_PWR_B;
				sub = {2'b00, int_evt.pwr_sub};
			end
			mce_pkg::MCE_SRC_TRUSTED: code = mce_pkg::CODE_TRUSTED;
			default: code = mce_pkg::CODE_UTILITY;
		endcase
		// software first, so a same-cycle hardware event overwrites it
		if (sw_wr.valid) begin
			if (sw_wr.hi) begin
				status_next[63:32] = sw_wr.data;
			end else begin
				status_next[31:0] = sw_wr.data;
			end
		end
		if (int_evt.valid) begin
			status_next = '0;
			status_next[mce_pkg::CODE_LSB +: 16] = code;
			status_next[mce_pkg::SUB_LSB +: 4] = sub;
			status_next[mce_pkg::DETAIL_LSB +: 8] = int_evt.detail;
			status_next[mce_pkg::INT_VALID_BIT] = 1'b1;
		end
		// three-strike copy takes priority over a plain internal error
		if (strike_evt.valid) begin
			status_next = strike_evt.cache_status;
			core_off_next = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			status_reg <= mce_pkg::INT_STATUS_RESET;
			core_off_reg <= 1'b0;
		end else begin
			status_reg <= status_next;
			core_off_reg <= core_off_next;
		end
	end

	assign status = status_reg;
	assign core_off = core_off_reg;

endmodule

// ===== hdl/mce_top.sv
`timescale 1ns/1ps
module mce_top #(
	parameter int NUM_BANKS = mce_pkg::NUM_BANKS
) (
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	input mce_pkg::mce_mc_evt_t MC_EVT,
	input mce_pkg::mce_int_evt_t INT_EVT,
	input mce_pkg::mce_strike_evt_t STRIKE_EVT,
	output logic EXT_LOG_EN,
	output logic CORE_BANKS_OFF
);

	localparam int IDX_W = (NUM_BANKS > 1) ? $clog2(NUM_BANKS) : 1;

	if (NUM_BANKS < 1 || NUM_BANKS > 8) begin : g_chk
		$error("mce_top: NUM_BANKS must be 1 to 8");
	end

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [63:0] put(input logic [15:0] v, input int lsb);
		logic [63:0] w;
		w = {48'h0, v};
		return w << lsb;
	endfunction

	function automatic logic is_misc(input logic [31:0] a);
		logic [11:0] off;
		off = a[11:0] - mce_pkg::OFF_MISC_BASE;
		return (a[31:12] == 20'h0) && (a[11:0] >= mce_pkg::OFF_MISC_BASE) &&
			(off < 12'(NUM_BANKS * 8)) && (a[1:0] == 2'b00);
	endfunction

	function automatic logic [IDX_W-1:0] misc_idx(input logic [31:0] a);
		logic [11:0] off;
		off = a[11:0] - mce_pkg::OFF_MISC_BASE;
		return off[IDX_W+2:3];
	endfunction

	function automatic logic is_reg(input logic [31:0] a, input logic [11:0] off);
		return (a[31:12] == 20'h0) && (a[11:0] == off);
	endfunction

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	mce_pkg::mce_state_t state_reg;
	mce_pkg::mce_state_t state_next;
	logic [31:0] addr_reg;
	logic [31:0] addr_next;
	logic hready_reg;
	logic hready_next;
	logic [31:0] hrdata_reg;
	logic [31:0] hrdata_next;
	logic hresp_reg;
	logic ext_en_reg;
	logic ext_en_next;
	logic [NUM_BANKS-1:0] v1_reg;
	logic [NUM_BANKS-1:0] v1_next;
	logic [NUM_BANKS-1:0] v2_reg;
	logic [NUM_BANKS-1:0] v2_next;
	logic [NUM_BANKS-1:0] drop_reg;
	logic [NUM_BANKS-1:0] drop_next;

	logic [4:0] bank_off;
	logic mc_hit;
	logic [IDX_W-1:0] log_idx;
	logic log_we;
	logic [63:0] log_mask;
	logic [63:0] log_data;
	logic [NUM_BANKS-1:0] drop_set;
	logic req;
	logic wr_apply;
	logic sw_misc_we;
	logic [IDX_W-1:0] sw_idx;
	logic [63:0] sw_mask;
	logic [63:0] sw_data;
	logic mem_we;
	logic [IDX_W-1:0] mem_waddr;
	logic [63:0] mem_wmask;
	logic [63:0] mem_wdata;
	logic [63:0] mem_rdata;
	logic [63:0] int_status;
	logic core_off;
	mce_pkg::mce_sw_wr_t int_sw_wr;

	// ------------------------------------------------------------
	// memory-controller event logging
	// ------------------------------------------------------------
	assign bank_off = MC_EVT.bank - mce_pkg::FIRST_BANK;
	assign mc_hit = MC_EVT.valid && (MC_EVT.bank >= mce_pkg::FIRST_BANK) &&
		(bank_off < 5'(NUM_BANKS));
	assign log_idx = bank_off[IDX_W-1:0];

	always_comb begin
		log_we = 1'b0;
		log_mask = '0;
		log_data = '0;
		drop_set = '0;
		if (mc_hit) begin
			case (MC_EVT.kind)
				mce_pkg::MCE_KIND_WR_DATA_PAR, mce_pkg::MCE_KIND_WR_BE_PAR: begin
					log_we = 1'b1;
					log_mask = put(mce_pkg::ONES5, mce_pkg::WBUF_LSB);
					log_data = put({11'h0, MC_EVT.wbuf_id}, mce_pkg::WBUF_LSB);
				end
				mce_pkg::MCE_KIND_CORR_READ: begin
					if (ext_en_reg) begin
						if (!v1_reg[log_idx]) begin
							log_we = 1'b1;
							log_mask = put(mce_pkg::ONES16, mce_pkg::MASK1_LSB) |
								put(mce_pkg::ONES5, mce_pkg::RANK1_LSB);
							log_data = put(MC_EVT.bit_mask, mce_pkg::MASK1_LSB) |
								put({11'h0, MC_EVT.rank}, mce_pkg::RANK1_LSB);
						end else if (!v2_reg[log_idx]) begin
							log_we = 1'b1;
							log_mask = put(mce_pkg::ONES16, mce_pkg::MASK2_LSB) |
								put(mce_pkg::ONES5, mce_pkg::RANK2_LSB) |
								put(mce_pkg::ONES5, mce_pkg::WBUF_LSB);
							log_data = put(MC_EVT.bit_mask, mce_pkg::MASK2_LSB) |
								put({11'h0, MC_EVT.rank}, mce_pkg::RANK2_LSB) |
								put({11'h0, MC_EVT.device}, mce_pkg::WBUF_LSB);
						end else begin
							// both slots full: first-device record is kept, the bank's drop flag is set
							drop_set[log_idx] = 1'b1;
						end
					end
				end
				default: begin
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// bus slave
	// ------------------------------------------------------------
	assign req = HSEL && HTRANS[1] && HREADY;
	// a software misc write waits out a hardware log to keep the single write port
	assign wr_apply = (state_reg == mce_pkg::MCE_ST_WR) && !(is_misc(addr_reg) && log_we);
	assign sw_misc_we = wr_apply && is_misc(addr_reg);
	assign sw_idx = misc_idx(addr_reg);
	assign sw_mask = addr_reg[2] ? (mce_pkg::MISC_SW_MASK & {32'hFFFF_FFFF, 32'h0}) :
		(mce_pkg::MISC_SW_MASK & {32'h0, 32'hFFFF_FFFF});
	assign sw_data = {HWDATA, HWDATA};

	assign mem_we = log_we || sw_misc_we;
	assign mem_waddr = log_we ? log_idx : sw_idx;
	assign mem_wmask = log_we ? log_mask : sw_mask;
	assign mem_wdata = log_we ? log_data : sw_data;

	always_comb begin
		int_sw_wr.valid = wr_apply &&
			(is_reg(addr_reg, mce_pkg::OFF_INT_LO) || is_reg(addr_reg, mce_pkg::OFF_INT_HI));
		int_sw_wr.hi = is_reg(addr_reg, mce_pkg::OFF_INT_HI);
		int_sw_wr.data = HWDATA;
	end

	always_comb begin
		state_next = state_reg;
		addr_next = addr_reg;
		hready_next = hready_reg;
		hrdata_next = hrdata_reg;
		ext_en_next = ext_en_reg;
		v1_next = v1_reg;
		v2_next = v2_reg;
		drop_next = drop_reg;
		case (state_reg)
			mce_pkg::MCE_ST_IDLE: begin
				if (req) begin
					addr_next = HADDR;
					hready_next = 1'b0;
					state_next = HWRITE ? mce_pkg::MCE_ST_WR : mce_pkg::MCE_ST_RD;
				end
			end
			mce_pkg::MCE_ST_RD: begin
				state_next = mce_pkg::MCE_ST_RD2;
			end
			mce_pkg::MCE_ST_RD2: begin
				hrdata_next = 32'h0;
				if (is_misc(addr_reg)) begin
					if (addr_reg[2]) begin
						hrdata_next = {v2_reg[sw_idx], v1_reg[sw_idx], 6'h00, mem_rdata[55:32]};
					end else begin
						hrdata_next = mem_rdata[31:0];
					end
				end else if (is_reg(addr_reg, mce_pkg::OFF_EXT_CTRL)) begin
					hrdata_next[mce_pkg::EXT_EN_BIT] = ext_en_reg;
				end else if (is_reg(addr_reg, mce_pkg::OFF_INT_LO)) begin
					hrdata_next = int_status[31:0];
				end else if (is_reg(addr_reg, mce_pkg::OFF_INT_HI)) begin
					hrdata_next = int_status[63:32];
				end else if (is_reg(addr_reg, mce_pkg::OFF_CORE)) begin
					hrdata_next = {31'h0, core_off};
				end else if (is_reg(addr_reg, mce_pkg::OFF_DROP)) begin
					hrdata_next = 32'(drop_reg);
				end
				hready_next = 1'b1;
				state_next = mce_pkg::MCE_ST_IDLE;
			end
			mce_pkg::MCE_ST_WR: begin
				if (wr_apply) begin
					if (is_reg(addr_reg, mce_pkg::OFF_EXT_CTRL)) begin
						ext_en_next = HWDATA[mce_pkg::EXT_EN_BIT];
					end
					if (is_reg(addr_reg, mce_pkg::OFF_DROP)) begin
						drop_next = drop_reg & ~HWDATA[NUM_BANKS-1:0];
					end
					if (sw_misc_we && addr_reg[2]) begin
						v1_next[sw_idx] = HWDATA[mce_pkg::VALID1_BIT-32];
						v2_next[sw_idx] = HWDATA[mce_pkg::VALID2_BIT-32];
					end
					hready_next = 1'b1;
					state_next = mce_pkg::MCE_ST_IDLE;
				end
			end
			default: begin
				hready_next = 1'b1;
				state_next = mce_pkg::MCE_ST_IDLE;
			end
		endcase
		// hardware capture wins over a software clear in the same cycle
		drop_next = drop_next | drop_set;
		if (log_we && (MC_EVT.kind == mce_pkg::MCE_KIND_CORR_READ)) begin
			if (!v1_reg[log_idx]) begin
				v1_next[log_idx] = 1'b1;
			end else begin
				v2_next[log_idx] = 1'b1;
			end
		end
		if (!ext_en_next) begin
			v1_next = '0;
			v2_next = '0;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			state_reg <= mce_pkg::MCE_ST_IDLE;
			addr_reg <= 32'h0;
			hready_reg <= 1'b1;
			hrdata_reg <= 32'h0;
			hresp_reg <= 1'b0;
			ext_en_reg <= mce_pkg::EXT_EN_RESET;
			v1_reg <= '0;
			v2_reg <= '0;
			drop_reg <= '0;
		end else begin
			state_reg <= state_next;
			addr_reg <= addr_next;
			hready_reg <= hready_next;
			hrdata_reg <= hrdata_next;
			hresp_reg <= 1'b0;
			ext_en_reg <= ext_en_next;
			v1_reg <= v1_next;
			v2_reg <= v2_next;
			drop_reg <= drop_next;
		end
	end

	// ------------------------------------------------------------
	// storage and internal-error bank
	// ------------------------------------------------------------
	mce_misc_mem #(
		.DEPTH(NUM_BANKS),
		.WIDTH(64),
		.AW(IDX_W)
	) u_misc (
		.clk(CLK),
		.we(mem_we),
		.waddr(mem_waddr),
		.wmask(mem_wmask),
		.wdata(mem_wdata),
		.re(state_reg == mce_pkg::MCE_ST_RD),
		.raddr(sw_idx),
		.rdata(mem_rdata)
	);

	// internal errors are kept apart from the memory banks
	mce_int_log u_int (
		.clk(CLK),
		.rstn(RSTN),
		.int_evt(INT_EVT),
		.strike_evt(STRIKE_EVT),
		.sw_wr(int_sw_wr),
		.status(int_status),
		.core_off(core_off)
	);

	assign HRDATA = hrdata_reg;
	assign HREADYOUT = hready_reg;
	assign HRESP = hresp_reg;
	assign EXT_LOG_EN = ext_en_reg;
	assign CORE_BANKS_OFF = core_off;

endmodule

// ===== dv/mce_monitor.sv
`timescale 1ns/1ps
module mce_monitor #(
	parameter int NUM_BANKS = 8
) (
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	input wire logic [31:0] HRDATA,
	input wire logic HREADYOUT,
	input wire logic HRESP,
	input mce_pkg::mce_mc_evt_t MC_EVT,
	input mce_pkg::mce_int_evt_t INT_EVT,
	input mce_pkg::mce_strike_evt_t STRIKE_EVT,
	input wire logic EXT_LOG_EN,
	input wire logic CORE_BANKS_OFF
);
	// ----------------
	// transfer tracking
	// ----------------
	logic taken;
	logic act_reg;
	logic w_reg;
	logic [31:0] a_reg;
	assign taken = HSEL && HTRANS[1] && HREADY && HREADYOUT;
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			act_reg <= 1'b0;
			w_reg <= 1'b0;
			a_reg <= 32'h0;
		end else if (taken) begin
			act_reg <= 1'b1;
			w_reg <= HWRITE;
			a_reg <= HADDR;
		end else if (HREADYOUT) begin
			act_reg <= 1'b0;
		end
	end
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RSTN);
	// ----------------
	// properties
	// ----------------
	property p_core_sticky;
		CORE_BANKS_OFF |=> CORE_BANKS_OFF;
	endproperty
	a_core_sticky: assert property (p_core_sticky) else $error("core banks came back");
	property p_strike_off;
		STRIKE_EVT.valid |=> CORE_BANKS_OFF;
	endproperty
	a_strike_off: assert property (p_strike_off) else $error("strike left core banks on");
	property p_core_read;
		act_reg && !w_reg && $rose(HREADYOUT) && a_reg == 32'hC |-> HRDATA[0] == CORE_BANKS_OFF;
	endproperty
	a_core_read: assert property (p_core_read) else $error("core flag readback wrong");
	property p_ext_write;
		act_reg && w_reg && a_reg == 32'h0 && $rose(HREADYOUT) |-> EXT_LOG_EN == $past(HWDATA[1]);
	endproperty
	a_ext_write: assert property (p_ext_write) else $error("enable not taken from write");
	property p_ext_read;
		act_reg && !w_reg && $rose(HREADYOUT) && a_reg == 32'h0 |-> HRDATA[1] == EXT_LOG_EN;
	endproperty
	a_ext_read: assert property (p_ext_read) else $error("enable readback wrong");
	property p_flags_off;
		act_reg && !w_reg && $rose(HREADYOUT) && a_reg[31:6] == 26'h4 && a_reg[2] && !EXT_LOG_EN
			|-> HRDATA[31:30] == 2'b00;
	endproperty
	a_flags_off: assert property (p_flags_off) else $error("valid flag while disabled");
	property p_read_wait;
		taken && !HWRITE |=> !HREADYOUT ##[1:4] HREADYOUT;
	endproperty
	a_read_wait: assert property (p_read_wait) else $error("read answer out of time");
	property p_unmapped;
		act_reg && !w_reg && $rose(HREADYOUT) && a_reg[31:12] != 20'h0 |-> HRDATA == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_resp_okay;
		!HRESP;
	endproperty
	a_resp_okay: assert property (p_resp_okay) else $error("response not okay");
endmodule
bind mce_top mce_monitor #(.NUM_BANKS(NUM_BANKS)) u_mon (.CLK(CLK), .RSTN(RSTN), .HSEL(HSEL),
	.HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
	.HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .MC_EVT(MC_EVT),
	.INT_EVT(INT_EVT), .STRIKE_EVT(STRIKE_EVT), .EXT_LOG_EN(EXT_LOG_EN),
	.CORE_BANKS_OFF(CORE_BANKS_OFF));

// ===== dv/mce_top_tb.sv
`timescale 1ns/1ps
module mce_top_tb;
	logic clk;
	logic rstn;
	logic hsel;
	logic hwrite;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic hready;
	logic hreadyout;
	logic hresp;
	logic ext_en;
	logic core_off;
	mce_pkg::mce_mc_evt_t mc_evt;
	mce_pkg::mce_int_evt_t int_evt;
	mce_pkg::mce_strike_evt_t strike_evt;
	int err_count;
	int tests_run;
	integer seed;
	logic me;
	logic [63:0] mm [9:16];
	logic [31:0] rd;
	logic [63:0] st;
	logic [63:0] ev;
	logic [15:0] cd;
	localparam logic [63:0] CM = mce_pkg::MISC_SW_MASK | 64'hC000_0000_0000_0000;
	localparam mce_pkg::mce_mc_kind_t KC = mce_pkg::MCE_KIND_CORR_READ;
	assign hready = hreadyout;
	mce_top #(.NUM_BANKS(8)) u_dut (.CLK(clk), .RSTN(rstn), .HSEL(hsel), .HADDR(haddr),
		.HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready),
		.HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .MC_EVT(mc_evt),
		.INT_EVT(int_evt), .STRIKE_EVT(strike_evt), .EXT_LOG_EN(ext_en),
		.CORE_BANKS_OFF(core_off));
	// ----------------
	// helpers
	// ----------------
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		tests_run++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] wd);
		int n;
		n = 0;
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= 3'h2;
		do begin
			@(posedge clk);
			n++;
		end while (hready !== 1'b1 && n < 50);
		htrans <= 2'h0;
		hwdata <= wd;
		do begin
			@(posedge clk);
			n++;
		end while (hready !== 1'b1 && n < 100);
		rd = hrdata;
		if (hready !== 1'b1) begin
			err_count++;
			$display("BAD hready exp 1 got %b", hready);
		end
	endtask
	task automatic rd64(input logic [31:0] a);
		xfer(a, 1'b0, 32'h0);
		st[31:0] = rd;
		xfer(a + 32'h4, 1'b0, 32'h0);
		st[63:32] = rd;
	endtask
	task automatic wr64(input logic [31:0] a, input logic [63:0] v);
		xfer(a, 1'b1, v[31:0]);
		xfer(a + 32'h4, 1'b1, v[63:32]);
	endtask
	function automatic logic [31:0] ma(input int b);
		return {20'h0, mce_pkg::OFF_MISC_BASE + 12'(8 * (b - 9))};
	endfunction
	task automatic chkm(input int b);
		repeat (4) @(posedge clk);
		rd64(ma(b));
		chk("misc", mm[b] & CM, st & CM);
	endtask
	// memory event plus its reference effect
	task automatic mc(input logic [4:0] b, input mce_pkg::mce_mc_kind_t k);
		logic [15:0] m;
		logic [4:0] r;
		logic [4:0] d;
		logic [4:0] w;
		m = 16'($random(seed));
		r = 5'($random(seed));
		d = 5'($random(seed));
		w = 5'($random(seed));
		mc_evt <= '{1'b1, b, k, w, d, m, r};
		@(posedge clk);
		mc_evt.valid <= 1'b0;
		@(posedge clk);
		if (b < 9 || b > 16 || k == mce_pkg::MCE_KIND_OTHER) return;
		if (k != KC) mm[b][13:9] = w;
		else if (me && !mm[b][62]) begin
			mm[b][29:14] = m;
			mm[b][50:46] = r;
			mm[b][62] = 1'b1;
		end else if (me && !mm[b][63]) begin
			mm[b][45:30] = m;
			mm[b][55:51] = r;
			mm[b][13:9] = d;
			mm[b][63] = 1'b1;
		end
	endtask
	// ----------------
	// sequence
	// ----------------
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		$display("BAD watchdog exp done got hang");
		give_verdict();
	end
	initial begin
		seed = 32'h57D7AC9D;
		err_count = 0;
		tests_run = 0;
		rstn = 1'b0;
		hsel = 1'b0;
		hwrite = 1'b0;
		htrans = 2'h0;
		hsize = 3'h2;
		haddr = 32'h0;
		hwdata = 32'h0;
		mc_evt = '0;
		int_evt = '0;
		strike_evt = '0;
		me = 1'b0;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		chk("ext_en", 64'h0, ext_en);
		chk("core_off", 64'h0, core_off);
		rd64(32'h4);
		chk("int_status", 64'h0, st);
		xfer(32'h0, 1'b1, 32'h2);
		me = 1'b1;
		chk("ext_en", 64'h1, ext_en);
		xfer(32'h0, 1'b0, 32'h0);
		chk("ext_ctrl", 64'h2, rd);
		for (int b = 9; b <= 16; b++) begin
			mm[b] = 64'h0;
			wr64(ma(b), 64'h0);
		end
		mc(5'h08, KC);
		mc(5'h11, KC);
		for (int b = 9; b <= 16; b++) begin
			mc(5'(b), KC);
			mc(5'(b), mce_pkg::MCE_KIND_OTHER);
			mc(5'(b), KC);
			chkm(b);
			mc(5'(b), KC);
			mc(5'(b), b[0] ? mce_pkg::MCE_KIND_WR_DATA_PAR : mce_pkg::MCE_KIND_WR_BE_PAR);
			chkm(b);
		end
		xfer(32'h10, 1'b0, 32'h0);
		chk("drop", 64'hFF, rd);
		xfer(32'h10, 1'b1, 32'hFF);
		xfer(32'h10, 1'b0, 32'h0);
		chk("drop", 64'h0, rd);
		xfer(32'h0, 1'b1, 32'h0);
		me = 1'b0;
		for (int b = 9; b <= 16; b++) mm[b][63:62] = 2'b00;
		chk("ext_en", 64'h0, ext_en);
		mc(5'h09, KC);
		mc(5'h0A, mce_pkg::MCE_KIND_WR_DATA_PAR);
		wr64(ma(11), mm[11] | 64'hC000_0000_0000_0000);
		for (int b = 9; b <= 16; b++) chkm(b);
		for (int s = 0; s < 4; s++) begin
			ev = 64'($random(seed));
			cd = 16'(s < 2 ? 32'h402 + s : 32'h404 + s);
			int_evt <= '{1'b1, mce_pkg::mce_int_src_t'(s), ev[1:0], ev[9:2]};
			@(posedge clk);
			int_evt.valid <= 1'b0;
			@(posedge clk);
			rd64(32'h4);
			chk("int_status", {1'b1, 31'h0, ev[9:2], 4'h0, s < 2 ? {2'b00, ev[1:0]} : 4'h0, cd},
				st);
		end
		chkm(9);
		ev = {$random(seed), $random(seed)};
		strike_evt <= '{1'b1, ev};
		int_evt <= '{1'b1, mce_pkg::MCE_SRC_UTILITY, 2'b00, 8'h5A};
		@(posedge clk);
		strike_evt.valid <= 1'b0;
		int_evt.valid <= 1'b0;
		@(posedge clk);
		chk("core_off", 64'h1, core_off);
		rd64(32'h4);
		chk("int_status", ev, st);
		xfer(32'hC, 1'b0, 32'h0);
		chk("core_flag", 64'h1, rd[0]);
		xfer(32'h1000, 1'b0, 32'h0);
		chk("unmapped", 64'h0, rd);
		rstn <= 1'b0;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		chk("core_off", 64'h0, core_off);
		rd64(32'h4);
		chk("int_status", 64'h0, st);
		xfer(32'hC, 1'b0, 32'h0);
		chk("core_flag", 64'h0, rd[0]);
		give_verdict();
	end
endmodule
